// File: hw/srs_map.svh
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH

// register addresses on the special-function register port
`define SRS_ADDR_REGULATOR_CONTROL 8'hC9
`define SRS_ADDR_SUPPLY_MONITOR_CONTROL 8'hFF
`define SRS_ADDR_RESET_CAUSE 8'hEF
`define SRS_ADDR_POWER_UNIT_MODE 8'hB3

// field positions
`define SRS_BIT_BIAS_FORCE 4
`define SRS_BIT_MON_ENABLE 7
`define SRS_BIT_SUPPLY_STAT 6
`define SRS_BIT_EARLY_OK 5
`define SRS_BIT_WARN_IE 3
`define SRS_BIT_POWER_ON_FLAG 1
`define SRS_BIT_SW_RESET 4
`define SRS_BIT_MON_DISABLE 5

// writable masks and reset values
`define SRS_MASK_REGULATOR_CONTROL 8'h10
`define SRS_RESET_REGULATOR_CONTROL 8'h00
`define SRS_RESET_MONITOR_ENABLE 1'b1
`define SRS_RESET_WARN_IE 1'b1
`define SRS_RESET_PORT_LATCH 8'hFF
`define SRS_RESET_VECTOR 16'h0000
`define SRS_WATCHDOG_DIVIDE 4'hC

// timing
`define SRS_CLK_PERIOD_NS 20
`define SRS_POR_DELAY_LOW_MS 7
`define SRS_POR_DELAY_HIGH_MS 15
`define SRS_MS_TO_CYCLES(ms) ((ms) * 1000000 / `SRS_CLK_PERIOD_NS)

`endif

// File: hw/srs_pkg.sv
package srs_pkg;

  typedef enum logic [1:0] {
    SRS_RUN = 2'b00,
    SRS_POR_HOLD = 2'b01,
    SRS_POR_DELAY = 2'b10,
    SRS_FAIL_HOLD = 2'b11
  } srs_state_t;

  typedef enum logic [1:0] {
    SRS_CAUSE_NONE = 2'b00,
    SRS_CAUSE_POWER_ON = 2'b01,
    SRS_CAUSE_SUPPLY_FAIL = 2'b10,
    SRS_CAUSE_OTHER = 2'b11
  } srs_cause_t;

endpackage

// File: hw/srs_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser for a bus of level inputs
module srs_sync #(
  parameter int WIDTH = 3
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } srs_sync_state_t;

  srs_sync_state_t state;
  srs_sync_state_t next_state;

  initial begin
    if (WIDTH < 1) begin
      $error("srs_sync needs WIDTH of at least 1");
    end
  end

  always_comb begin
    next_state = state;
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage2;

endmodule

// File: hw/srs_supply_reset_sequencer.sv
`timescale 1ns/1ps
`include "srs_map.svh"

// What this block does
// [R1] regulator off in Sleep, on in Suspend
// [R2] bias-force bit holds oscillator bias on outside Sleep
// [R3] reserved regulator bits written zero, read zero
// [R4] reset halts core, loads registers, quiets
// [R5] reset keeps RAM, resets stack pointer
// [R6] port latches 0xFF open-drain, pull-ups kept
// [R7] reset pin: float on POR, low on fail
// [R8] exit: PC zero, internal clock, watchdog/12
// [R9] power-on delay after supply passes threshold
// [R10] power-on flag set by POR or supply-fail reset, else cleared
// [R11] monitor-disable makes every reset except a supply-fail reset a full POR
// [R12] POR and fail reset enable, select monitor
// [R13] supply below reset threshold holds reset
// [R14] fail reset reports power-on flag, RAM invalid
// [R15] other resets keep monitor settings
// [R16] Sleep suppresses fail reset, restores on wake
// [R17] early-ok flag clears below warning threshold
// [R18] flash write without monitor forces reset
// [R19] supply-fail reset releases without power-on delay
// [R20] software writes power-on flag as one
// [R21] software enables monitor before selecting it
// [R22] monitor control bit 7 switches the monitor
// [R23] monitor control bit 3 enables warning irq
// [R24] threshold comparisons synchronised before use
module srs_supply_reset_sequencer #(
  parameter int POR_DELAY_LOW_CYCLES = `SRS_MS_TO_CYCLES(`SRS_POR_DELAY_LOW_MS),
  parameter int POR_DELAY_HIGH_CYCLES = `SRS_MS_TO_CYCLES(`SRS_POR_DELAY_HIGH_MS),
  parameter int DELAY_WIDTH = 20
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic above_power_on_threshold,
  input wire logic above_reset_threshold,
  input wire logic above_warning_threshold,
  input wire logic supply_is_high,
  input wire logic sleep_request,
  input wire logic suspend_request,
  input wire logic wake_event,
  input wire logic other_reset_request,
  input wire logic flash_write_attempt,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic core_in_reset,
  output logic core_regulator_enable,
  output logic precision_bias_on,
  output logic [7:0] port_latch,
  output logic port_open_drain,
  output logic weak_pullup_enable,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic reset_pin_pullup,
  output logic [15:0] program_counter_init,
  output logic internal_osc_select,
  output logic watchdog_enable,
  output logic [3:0] watchdog_divide,
  output logic interrupts_disable,
  output logic stack_reset,
  output logic ram_valid,
  output logic early_warning_irq
);

  typedef struct packed {
    srs_pkg::srs_state_t mode;
    srs_pkg::srs_cause_t cause;
    logic [DELAY_WIDTH-1:0] delay_count;
    logic precision_bias_force;
    logic supply_monitor_enable;
    logic monitor_selected;
    logic early_warning_irq_enable;
    logic por_monitor_disable;
    logic power_on_flag;
    logic sleeping;
    logic suspended;
    logic [7:0] rdata;
    logic core_in_reset;
    logic regulator_on;
    logic bias_on;
    logic pin_drive_low;
    logic pin_pullup;
    logic ram_ok;
    logic irq;
  } srs_top_state_t;

  srs_top_state_t state;
  srs_top_state_t next_state;
  logic [2:0] sync_levels;
  logic por_ok;
  logic rst_ok;
  logic warn_ok;

  initial begin
    if (POR_DELAY_LOW_CYCLES < 1 || POR_DELAY_HIGH_CYCLES < 1) begin
      $error("power-on delay counts must be at least one cycle");
    end
    if (POR_DELAY_HIGH_CYCLES >= (1 << DELAY_WIDTH) || POR_DELAY_LOW_CYCLES >= (1 << DELAY_WIDTH)) begin
      $error("DELAY_WIDTH too small for the power-on delay");
    end
  end

  srs_sync #(
    .WIDTH(3)
  ) u_sync ( // [R24]
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in({above_power_on_threshold, above_reset_threshold, above_warning_threshold}),
    .sync_out(sync_levels)
  );

  assign por_ok = sync_levels[2];
  assign rst_ok = sync_levels[1];
  assign warn_ok = sync_levels[0];

  function automatic logic [DELAY_WIDTH-1:0] por_delay(input logic high);
    por_delay = high ? DELAY_WIDTH'(POR_DELAY_HIGH_CYCLES) : DELAY_WIDTH'(POR_DELAY_LOW_CYCLES);
  endfunction

  // power-on style entry: monitor forced on and selected
  function automatic srs_top_state_t enter_por(input srs_top_state_t s);
    srs_top_state_t t;
    t = s;
    t.mode = srs_pkg::SRS_POR_HOLD;
    t.cause = srs_pkg::SRS_CAUSE_POWER_ON;
    t.supply_monitor_enable = `SRS_RESET_MONITOR_ENABLE; // [R12]
    t.monitor_selected = 1'b1; // [R12]
    t.por_monitor_disable = 1'b0; // [R11]
    t.precision_bias_force = 1'b0;
    t.early_warning_irq_enable = `SRS_RESET_WARN_IE;
    t.ram_ok = 1'b0;
    t.core_in_reset = 1'b1; // [R4]
    t.sleeping = 1'b0;
    t.suspended = 1'b0;
    enter_por = t;
  endfunction

  always_comb begin
    logic monitor_active;
    logic [7:0] rd;
    monitor_active = 1'b0;
    rd = 8'h00;
    next_state = state;
    monitor_active = state.supply_monitor_enable && state.monitor_selected && !state.sleeping; // [R16]

    unique case (state.mode)
      srs_pkg::SRS_RUN: begin
        next_state.core_in_reset = 1'b0;
        // ram holds valid data once the core has run after a reset
        next_state.ram_ok = 1'b1;
        if (!por_ok) begin
          next_state = enter_por(state);
        end else if (monitor_active && !rst_ok) begin // [R13]
          next_state.mode = srs_pkg::SRS_FAIL_HOLD;
          next_state.cause = srs_pkg::SRS_CAUSE_SUPPLY_FAIL;
          next_state.supply_monitor_enable = 1'b1; // [R12]
          next_state.monitor_selected = 1'b1;
          next_state.ram_ok = 1'b0; // [R14]
          next_state.core_in_reset = 1'b1; // [R4]
        end else if (other_reset_request || (flash_write_attempt && !state.supply_monitor_enable)) begin // [R18]
          if (state.por_monitor_disable) begin
            next_state = enter_por(state); // [R11]
          end else begin
            // monitor enable and select untouched by this kind of reset; warning irq enable reloaded
            next_state.mode = srs_pkg::SRS_POR_DELAY; // [R15]
            next_state.cause = srs_pkg::SRS_CAUSE_OTHER;
            next_state.delay_count = DELAY_WIDTH'(1);
            next_state.precision_bias_force = 1'b0;
            next_state.early_warning_irq_enable = `SRS_RESET_WARN_IE;
            next_state.core_in_reset = 1'b1; // [R4]
          end
        end else begin
          if (sleep_request) begin
            next_state.sleeping = 1'b1;
          end else if (suspend_request) begin
            next_state.suspended = 1'b1;
          end
          if (wake_event) begin
            next_state.sleeping = 1'b0; // [R16]
            next_state.suspended = 1'b0;
          end
          if (sfr_write) begin
            unique case (sfr_addr)
              `SRS_ADDR_REGULATOR_CONTROL: begin
                next_state.precision_bias_force = sfr_wdata[`SRS_BIT_BIAS_FORCE]; // [R3]
              end
              `SRS_ADDR_SUPPLY_MONITOR_CONTROL: begin
                next_state.supply_monitor_enable = sfr_wdata[`SRS_BIT_MON_ENABLE]; // [R22]
                next_state.early_warning_irq_enable = sfr_wdata[`SRS_BIT_WARN_IE]; // [R23]
              end
              `SRS_ADDR_RESET_CAUSE: begin
                next_state.monitor_selected = sfr_wdata[`SRS_BIT_POWER_ON_FLAG]; // [R20]
                if (sfr_wdata[`SRS_BIT_SW_RESET]) begin
                  next_state.mode = state.por_monitor_disable ? srs_pkg::SRS_POR_HOLD : srs_pkg::SRS_POR_DELAY;
                  next_state.cause = state.por_monitor_disable ? srs_pkg::SRS_CAUSE_POWER_ON
                                                               : srs_pkg::SRS_CAUSE_OTHER;
                  next_state.delay_count = DELAY_WIDTH'(1);
                  next_state.core_in_reset = 1'b1;
                end
              end
              `SRS_ADDR_POWER_UNIT_MODE: begin
                next_state.por_monitor_disable = sfr_wdata[`SRS_BIT_MON_DISABLE]; // [R11]
              end
              default: begin
              end
            endcase
          end
        end
      end
      srs_pkg::SRS_POR_HOLD: begin
        next_state.core_in_reset = 1'b1;
        next_state.delay_count = por_delay(supply_is_high); // [R9]
        if (por_ok) begin
          next_state.mode = srs_pkg::SRS_POR_DELAY;
        end
      end
      srs_pkg::SRS_POR_DELAY: begin
        next_state.core_in_reset = 1'b1;
        if (!por_ok) begin
          next_state = enter_por(state);
        end else if (state.delay_count <= DELAY_WIDTH'(1)) begin
          next_state.mode = srs_pkg::SRS_RUN; // [R8]
          next_state.core_in_reset = 1'b0;
          next_state.power_on_flag = (state.cause == srs_pkg::SRS_CAUSE_POWER_ON); // [R10]
        end else begin
          next_state.delay_count = state.delay_count - DELAY_WIDTH'(1); // [R9]
        end
      end
      srs_pkg::SRS_FAIL_HOLD: begin
        next_state.core_in_reset = 1'b1;
        if (!por_ok) begin
          next_state = enter_por(state);
        end else if (rst_ok) begin
          next_state.mode = srs_pkg::SRS_RUN; // [R19]
          next_state.core_in_reset = 1'b0;
          next_state.power_on_flag = 1'b1; // [R14]
        end
      end
    endcase

    // outputs registered from the next state, irq from the current enable
    next_state.regulator_on = !next_state.sleeping; // [R1]
    next_state.bias_on = next_state.precision_bias_force && !next_state.sleeping; // [R2]
    next_state.pin_drive_low = (next_state.mode == srs_pkg::SRS_FAIL_HOLD); // [R7]
    next_state.pin_pullup = (next_state.mode != srs_pkg::SRS_POR_HOLD && next_state.mode != srs_pkg::SRS_POR_DELAY)
                            || next_state.cause != srs_pkg::SRS_CAUSE_POWER_ON;
    if (next_state.mode == srs_pkg::SRS_RUN && state.mode != srs_pkg::SRS_RUN) begin
      next_state.ram_ok = (state.cause == srs_pkg::SRS_CAUSE_OTHER) ? state.ram_ok : 1'b0; // [R5] [R14]
    end
    next_state.irq = state.early_warning_irq_enable && !warn_ok; // [R17]

    if (sfr_read) begin
      unique case (sfr_addr)
        `SRS_ADDR_REGULATOR_CONTROL: begin
          rd = {3'h0, state.precision_bias_force, 4'h0}; // [R3]
        end
        `SRS_ADDR_SUPPLY_MONITOR_CONTROL: begin
          rd = {state.supply_monitor_enable, rst_ok, warn_ok, 1'b0, state.early_warning_irq_enable, 3'h0}; // [R17]
        end
        `SRS_ADDR_RESET_CAUSE: begin
          rd = {6'h00, state.power_on_flag, 1'b0};
        end
        `SRS_ADDR_POWER_UNIT_MODE: begin
          rd = {2'h0, state.por_monitor_disable, 5'h00};
        end
        default: begin
          rd = 8'h00;
        end
      endcase
      next_state.rdata = rd;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= '0;
      state.mode <= srs_pkg::SRS_POR_HOLD;
      state.cause <= srs_pkg::SRS_CAUSE_POWER_ON;
      state.supply_monitor_enable <= `SRS_RESET_MONITOR_ENABLE;
      state.monitor_selected <= 1'b1;
      state.early_warning_irq_enable <= `SRS_RESET_WARN_IE;
      state.core_in_reset <= 1'b1;
      state.regulator_on <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign sfr_rdata = state.rdata;
  assign core_in_reset = state.core_in_reset; // [R4]
  assign core_regulator_enable = state.regulator_on;
  assign precision_bias_on = state.bias_on;
  assign port_latch = `SRS_RESET_PORT_LATCH; // [R6]
  assign port_open_drain = state.core_in_reset;
  assign weak_pullup_enable = 1'b1; // [R6]
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = !state.pin_drive_low; // [R7]
  assign reset_pin_pullup = state.pin_pullup;
  assign program_counter_init = `SRS_RESET_VECTOR; // [R8]
  assign internal_osc_select = state.core_in_reset;
  assign watchdog_enable = state.core_in_reset;
  assign watchdog_divide = `SRS_WATCHDOG_DIVIDE;
  assign interrupts_disable = state.core_in_reset;
  assign stack_reset = state.core_in_reset; // [R5]
  assign ram_valid = state.ram_ok;
  assign early_warning_irq = state.irq;

endmodule

// File: dv/srs_supply_reset_sequencer_chk.sv
`timescale 1ns/1ps
module srs_supply_reset_sequencer_chk #(
  parameter int POR_DELAY_LOW_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic above_power_on_threshold,
  input wire logic above_reset_threshold,
  input wire logic above_warning_threshold,
  input wire logic sleep_request,
  input wire logic suspend_request,
  input wire logic wake_event,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_rdata,
  input wire logic core_in_reset,
  input wire logic core_regulator_enable,
  input wire logic precision_bias_on,
  input wire logic [7:0] port_latch,
  input wire logic port_open_drain,
  input wire logic weak_pullup_enable,
  input wire logic reset_pin_oe,
  input wire logic reset_pin_pullup,
  input wire logic [15:0] program_counter_init,
  input wire logic [3:0] watchdog_divide,
  input wire logic stack_reset
);
  int por_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // cycles spent in power-on reset with the supply already above threshold
  always_ff @(posedge sys_clk) begin
    if (!core_in_reset || reset_pin_pullup || !above_power_on_threshold) por_cnt <= 0;
    else por_cnt <= por_cnt + 1;
  end
  sequence s_supply_back;
    $rose(above_reset_threshold) && !reset_pin_oe && above_power_on_threshold;
  endsequence
  sequence s_core_runs;
    ##[1:6] !core_in_reset;
  endsequence
  property p_fail_release;
    s_supply_back |-> s_core_runs;
  endproperty
  a_fail_release: assert property (p_fail_release) else $error("fail reset held too long");
  property p_pin_low;
    !reset_pin_oe |-> core_in_reset && reset_pin_pullup;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("reset pin driven outside fail reset");
  property p_por_delay;
    $fell(core_in_reset) && por_cnt > 3 |-> por_cnt >= POR_DELAY_LOW_CYCLES;
  endproperty
  a_por_delay: assert property (p_por_delay) else $error("power-on delay too short");
  property p_sleep;
    sleep_request && !core_in_reset && !wake_event && !suspend_request |-> ##[1:2] !core_regulator_enable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("regulator left on in sleep");
  property p_suspend;
    suspend_request && !sleep_request && core_regulator_enable |=> core_regulator_enable;
  endproperty
  a_suspend: assert property (p_suspend) else $error("regulator off in suspend");
  property p_bias;
    !core_regulator_enable |-> !precision_bias_on;
  endproperty
  a_bias: assert property (p_bias) else $error("bias on while asleep");
  property p_follow;
    port_open_drain == core_in_reset && stack_reset == core_in_reset;
  endproperty
  a_follow: assert property (p_follow) else $error("reset side outputs do not follow reset");
  property p_port;
    port_latch == 8'hFF && weak_pullup_enable;
  endproperty
  a_port: assert property (p_port) else $error("port latch or pull-up wrong");
  property p_exit;
    program_counter_init == 16'h0000 && watchdog_divide == 4'hC;
  endproperty
  a_exit: assert property (p_exit) else $error("exit vector or watchdog divide wrong");
  property p_reg_read;
    sfr_read && !core_in_reset && sfr_addr == 8'hC9 |=> (sfr_rdata & 8'hEF) == 8'h00;
  endproperty
  a_reg_read: assert property (p_reg_read) else $error("reserved regulator bits read non-zero");
endmodule
bind srs_supply_reset_sequencer srs_supply_reset_sequencer_chk #(
  .POR_DELAY_LOW_CYCLES(POR_DELAY_LOW_CYCLES)
) u_chk (
  .sys_clk(sys_clk), .reset(reset), .above_power_on_threshold(above_power_on_threshold),
  .above_reset_threshold(above_reset_threshold), .above_warning_threshold(above_warning_threshold),
  .sleep_request(sleep_request), .suspend_request(suspend_request), .wake_event(wake_event),
  .sfr_read(sfr_read), .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata), .core_in_reset(core_in_reset),
  .core_regulator_enable(core_regulator_enable), .precision_bias_on(precision_bias_on),
  .port_latch(port_latch), .port_open_drain(port_open_drain), .weak_pullup_enable(weak_pullup_enable),
  .reset_pin_oe(reset_pin_oe), .reset_pin_pullup(reset_pin_pullup),
  .program_counter_init(program_counter_init), .watchdog_divide(watchdog_divide), .stack_reset(stack_reset)
);

// File: dv/srs_supply_reset_sequencer_tb.sv
`timescale 1ns/1ps
module srs_supply_reset_sequencer_tb;
  localparam int LOW = 20;
  localparam int HIGH = 40;
  logic sys_clk, reset, por_ok, rst_ok, warn_ok, sup_hi, sleep_rq, susp_rq, wake, oth_rq, flash_rq, wr_s, rd_s;
  logic [7:0] addr, wdata, rdata, d;
  logic cir, reg_en, bias, pin_oe, pin_pu, ram_ok, irq;
  int err_total, cmp_count, n;
  // address, write data, read mask, expected read
  logic [31:0] rows [7] = '{32'hC9FFFF10, 32'hC900FF00, 32'hFF009F00, 32'hFF88FFE8, 32'hEF020202,
                            32'hB3002000, 32'h12AAFF00};
  srs_supply_reset_sequencer #(
    .POR_DELAY_LOW_CYCLES(LOW),
    .POR_DELAY_HIGH_CYCLES(HIGH),
    .DELAY_WIDTH(20)
  ) dut (
    .sys_clk(sys_clk), .reset(reset), .above_power_on_threshold(por_ok), .above_reset_threshold(rst_ok),
    .above_warning_threshold(warn_ok), .supply_is_high(sup_hi), .sleep_request(sleep_rq),
    .suspend_request(susp_rq), .wake_event(wake), .other_reset_request(oth_rq), .flash_write_attempt(flash_rq),
    .sfr_write(wr_s), .sfr_read(rd_s), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .core_in_reset(cir), .core_regulator_enable(reg_en), .precision_bias_on(bias), .port_latch(),
    .port_open_drain(), .weak_pullup_enable(), .reset_pin_out(), .reset_pin_oe(pin_oe),
    .reset_pin_pullup(pin_pu), .program_counter_init(), .internal_osc_select(), .watchdog_enable(),
    .watchdog_divide(), .interrupts_disable(), .stack_reset(), .ram_valid(ram_ok), .early_warning_irq(irq)
  );
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: sleep_rq <= 1'b1;
      1: susp_rq <= 1'b1;
      2: wake <= 1'b1;
      3: oth_rq <= 1'b1;
      default: flash_rq <= 1'b1;
    endcase
    @(posedge sys_clk);
    {sleep_rq, susp_rq, wake, oth_rq, flash_rq} <= 5'h00;
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_lvl(input logic lvl, input int max, output int c);
    c = 0;
    #1;
    while (cir !== lvl && c < max) begin
      settle(1);
      c++;
    end
    if (cir !== lvl) begin
      err_total++;
      $display("Error at %0t: core reset wait expired", $time);
      summarize();
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    {reset, por_ok, rst_ok, warn_ok} = 4'hF;
    {sup_hi, sleep_rq, susp_rq, wake, oth_rq, flash_rq, wr_s, rd_s} = 8'h00;
    {addr, wdata} = 16'h0000;
    err_total = 0;
    cmp_count = 0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    settle(1);
    chk(8'({pin_oe, pin_pu, cir}), 8'h05);
    wait_lvl(1'b0, 200, n);
    chk(8'(n >= LOW && n <= LOW + 8), 8'h01);
    rd(8'hEF, d);
    chk(d & 8'h02, 8'h02);
    rd(8'hFF, d);
    chk(d & 8'h88, 8'h88);
    $display("done: power-on");
    for (int i = 0; i < 7; i++) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd(rows[i][31:24], d);
      chk(d & rows[i][15:8], rows[i][7:0]);
    end
    $display("done: registers");
    wr(8'hC9, 8'h10);
    settle(1);
    chk(8'(bias), 8'h01);
    pulse(0);
    rst_ok <= 1'b0;
    settle(10);
    chk(8'({reg_en, cir}), 8'h00);
    @(posedge sys_clk);
    rst_ok <= 1'b1;
    repeat (4) @(posedge sys_clk);
    pulse(2);
    settle(3);
    chk(8'(reg_en), 8'h01);
    pulse(1);
    settle(3);
    chk(8'(reg_en), 8'h01);
    pulse(2);
    rd(8'hFF, d);
    chk(d & 8'h80, 8'h80);
    $display("done: low power");
    @(posedge sys_clk);
    warn_ok <= 1'b0;
    settle(5);
    chk(8'(irq), 8'h01);
    rd(8'hFF, d);
    chk(d & 8'h20, 8'h00);
    wr(8'hFF, 8'h80);
    settle(2);
    chk(8'(irq), 8'h00);
    @(posedge sys_clk);
    warn_ok <= 1'b1;
    wr(8'hFF, 8'h88);
    $display("done: warning");
    rst_ok <= 1'b0;
    wait_lvl(1'b1, 10, n);
    chk(8'(pin_oe), 8'h00);
    @(posedge sys_clk);
    rst_ok <= 1'b1;
    wait_lvl(1'b0, 10, n);
    chk(8'(ram_ok), 8'h00);
    rd(8'hEF, d);
    chk(d & 8'h02, 8'h02);
    rd(8'hFF, d);
    chk(d & 8'h80, 8'h80);
    $display("done: supply fail");
    wr(8'hEF, 8'h00);
    wr(8'hFF, 8'h08);
    pulse(3);
    wait_lvl(1'b1, 10, n);
    wait_lvl(1'b0, 10, n);
    chk(8'(ram_ok), 8'h01);
    rd(8'hEF, d);
    chk(d & 8'h02, 8'h00);
    rd(8'hFF, d);
    chk(d & 8'h88, 8'h08);
    pulse(4);
    wait_lvl(1'b1, 10, n);
    wait_lvl(1'b0, 10, n);
    wr(8'hB3, 8'h20);
    pulse(3);
    wait_lvl(1'b1, 10, n);
    wait_lvl(1'b0, 200, n);
    chk(8'(n >= LOW), 8'h01);
    rd(8'hEF, d);
    chk(d & 8'h02, 8'h02);
    rd(8'hFF, d);
    chk(d & 8'h80, 8'h80);
    wr(8'hC9, 8'h10);
    sup_hi <= 1'b1;
    por_ok <= 1'b0;
    wait_lvl(1'b1, 10, n);
    @(posedge sys_clk);
    por_ok <= 1'b1;
    wait_lvl(1'b0, 200, n);
    chk(8'(n >= HIGH && n <= HIGH + 8), 8'h01);
    rd(8'hC9, d);
    chk(d, 8'h00);
    $display("done: other resets");
    summarize();
  end
endmodule
